// >>> console_ctl_map.svh
// offsets, field positions, reset values and timing counts of the console control block
`ifndef CONSOLE_CTL_MAP_SVH
`define CONSOLE_CTL_MAP_SVH

// register offsets (byte addresses)
`define CC_PANEL_OFS 8'h00
`define CC_STATUS_OFS 8'h04

// panel register fields
`define CC_PANEL_LOGIC_LSB 0
`define CC_PANEL_SCALE_LSB 2
`define CC_PANEL_ANALOG_LSB 4
`define CC_PANEL_SLAVE_BIT 6

// status register fields
`define CC_STAT_LOGIC_LSB 0
`define CC_STAT_SCALE_LSB 2
`define CC_STAT_ANALOG_LSB 4
`define CC_STAT_SLAVE_BIT 6
`define CC_STAT_EN_LSB 7

// reset values
`define CC_PANEL_LOGIC_RST 2'h0
`define CC_PANEL_SCALE_RST 2'h0
`define CC_PANEL_ANALOG_RST 2'h0
`define CC_PANEL_SLAVE_RST 1'h0

// timing
`define CC_CLK_PERIOD_NS 5
`define CC_TIMEBASE_PERIOD_NS 1000
`define CC_TB_HALF_CYCLES ((`CC_TIMEBASE_PERIOD_NS / `CC_CLK_PERIOD_NS) / 2)

`endif

// >>> console_ctl_pkg.sv
// types of the console control block
package console_ctl_pkg;

  typedef enum logic [1:0] {
    LM_LOAD = 2'h0,
    LM_RUN = 2'h1,
    LM_STOP = 2'h2
  } logic_mode_t;

  // held as {hundreds, tens}
  typedef enum logic [1:0] {
    TS_X1 = 2'h0,
    TS_X10 = 2'h1,
    TS_X100 = 2'h2,
    TS_X1000 = 2'h3
  } time_scale_t;

  typedef enum logic [1:0] {
    AM_IC = 2'h0,
    AM_OP = 2'h1,
    AM_HOLD = 2'h2,
    AM_MHOLD = 2'h3
  } analog_mode_t;

  typedef enum logic {
    TB_LOW = 1'b0,
    TB_HIGH = 1'b1
  } tb_phase_t;

  // patched inputs, pin level: 0 V is logic one
  typedef struct packed {
    logic console_logic_override_en;
    logic console_halt_in;
    logic console_run_in;
    logic console_scale_override_en;
    logic console_scale_tens_in;
    logic console_scale_hundreds_in;
    logic console_analog_override_en;
    logic console_master_hold_in;
    logic console_hold_in;
    logic console_operate_in;
    logic console_clock_override_en;
    logic outside_timebase_en;
    logic outside_timebase_in;
    logic overload_gate_en;
    logic follower_enable_in;
  } patch_pins_n_t;

  // patchboard outputs, pin level: 0 V is logic one
  typedef struct packed {
    logic system_halt_out;
    logic system_run_out;
    logic system_scale_tens_out;
    logic system_scale_hundreds_out;
    logic logic_timebase_out;
    logic follower_button_out;
    logic overload_report_out;
  } board_pins_n_t;

  typedef struct packed {
    tb_phase_t phase;
    logic [6:0] count;
    logic rise;
  } tb_state_t;

  typedef struct packed {
    logic_mode_t panel_logic;
    time_scale_t panel_scale;
    analog_mode_t panel_analog;
    logic slave_button;
    logic_mode_t con_logic;
    time_scale_t con_scale;
    analog_mode_t con_analog;
    logic ext_prev;
    logic tick;
    logic [31:0] rdata;
    board_pins_n_t pins;
  } ctl_state_t;

endpackage

// >>> timebase_gen.sv
// internal 1 MHz logic time base generator
`timescale 1ns/100ps
`default_nettype none
`include "console_ctl_map.svh"

module timebase_gen
  import console_ctl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // time base
  output logic level,
  output logic rise
);

  localparam logic [6:0] HALF_LAST = 7'(`CC_TB_HALF_CYCLES - 1);

  tb_state_t st;
  tb_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.rise = 1'b0;
    if (st.count == HALF_LAST) begin
      next_st.count = 7'h00;
      case (st.phase)
        TB_LOW: begin
          next_st.phase = TB_HIGH;
          next_st.rise = 1'b1;
        end
        TB_HIGH: next_st.phase = TB_LOW;
        default: next_st.phase = TB_LOW;
      endcase
    end else begin
      next_st.count = st.count + 7'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{phase: TB_LOW, count: 7'h00, rise: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level = (st.phase == TB_HIGH);
  assign rise = st.rise;

endmodule
`default_nettype wire

// >>> console_mode_override.sv
// console-level logic mode, time scale, clock and slaving control
// Functional notes
// - System logic mode is shown on halt then run outputs: load 00, run 01, stop 10.
// - With logic override enabled the console logic mode follows the patched halt and run.
// - Patched decode: load when both 0, run when only run is 1, stop whenever halt is 1.
// - System time scale is shown on tens and hundreds: x1 00, x10 10, x100 01, x1000 11.
// - With scale override enabled the console scale follows the patched tens and hundreds.
// - The internal 1 MHz time base is an output; the outside time base replaces it as the logic clock when its own enable, clock override or follower enable is on.
// - The latched slave button is driven onto a patchable follower output.
// - Follower enable moves analog mode, time scale and clock control to the patched inputs.
// - Follower enable gates the overload indication onto the overload output.
// - Follower enable equals all five enables together; each enable also works alone.
// - Patched control levels are inverted: logic one is 0 V, logic zero is +5 V.
// - With analog override enabled the console analog mode follows master hold, hold, operate.
// - An unpatched input to an enabled function reads as logic zero.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "console_ctl_map.svh"

module console_mode_override
  import console_ctl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // patchboard
  input wire patch_pins_n_t patch_n,
  output board_pins_n_t board_n,
  // overload detector of this console
  input wire logic overload_detect,
  // console selections
  output logic_mode_t console_logic_mode,
  output time_scale_t console_scale,
  output analog_mode_t console_analog_mode,
  output logic logic_tick
);

  ctl_state_t st;
  ctl_state_t next_st;
  logic tb_level;
  logic tb_rise;

  timebase_gen u_timebase (
    .mclk(mclk),
    .rst(rst),
    .level(tb_level),
    .rise(tb_rise)
  );

  // pin levels to logic; a floating pin sits at +5 V and so reads as zero
  logic follower_en;
  logic logic_en;
  logic scale_en;
  logic analog_en;
  logic clock_en;
  logic ovl_en;
  logic ext_sel;
  logic ext_level;
  logic ext_rise;
  logic active_tick;
  logic_mode_t patched_logic;
  time_scale_t patched_scale;
  analog_mode_t patched_analog;
  logic_mode_t wr_logic;

  always_comb begin
    follower_en = ~patch_n.follower_enable_in;
    logic_en = ~patch_n.console_logic_override_en | follower_en;
    scale_en = ~patch_n.console_scale_override_en | follower_en;
    analog_en = ~patch_n.console_analog_override_en | follower_en;
    clock_en = ~patch_n.console_clock_override_en | follower_en;
    ovl_en = ~patch_n.overload_gate_en | follower_en;
    ext_sel = ~patch_n.outside_timebase_en | clock_en;
    ext_level = ~patch_n.outside_timebase_in;
    ext_rise = ext_level & ~st.ext_prev;
    active_tick = ext_sel ? ext_rise : tb_rise;
    // halt wins over run
    if (~patch_n.console_halt_in) begin
      patched_logic = LM_STOP;
    end else if (~patch_n.console_run_in) begin
      patched_logic = LM_RUN;
    end else begin
      patched_logic = LM_LOAD;
    end
    patched_scale = time_scale_t'({~patch_n.console_scale_hundreds_in,
                                   ~patch_n.console_scale_tens_in});
    if (~patch_n.console_master_hold_in) begin
      patched_analog = AM_MHOLD;
    end else if (~patch_n.console_hold_in) begin
      patched_analog = AM_HOLD;
    end else if (~patch_n.console_operate_in) begin
      patched_analog = AM_OP;
    end else begin
      patched_analog = AM_IC;
    end
    // an unused 11 code from software is taken as stop
    if (reg_wdata[`CC_PANEL_LOGIC_LSB + 1]) begin
      wr_logic = LM_STOP;
    end else begin
      wr_logic = logic_mode_t'(reg_wdata[`CC_PANEL_LOGIC_LSB +: 2]);
    end
  end

  always_comb begin
    next_st = st;
    next_st.ext_prev = ext_level;
    next_st.tick = active_tick;
    next_st.rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == `CC_PANEL_OFS) begin
      next_st.panel_logic = wr_logic;
      next_st.panel_scale = time_scale_t'(reg_wdata[`CC_PANEL_SCALE_LSB +: 2]);
      next_st.panel_analog = analog_mode_t'(reg_wdata[`CC_PANEL_ANALOG_LSB +: 2]);
      next_st.slave_button = reg_wdata[`CC_PANEL_SLAVE_BIT];
    end
    if (reg_rd) begin
      case (reg_addr)
        `CC_PANEL_OFS: begin
          next_st.rdata[`CC_PANEL_LOGIC_LSB +: 2] = st.panel_logic;
          next_st.rdata[`CC_PANEL_SCALE_LSB +: 2] = st.panel_scale;
          next_st.rdata[`CC_PANEL_ANALOG_LSB +: 2] = st.panel_analog;
          next_st.rdata[`CC_PANEL_SLAVE_BIT] = st.slave_button;
        end
        `CC_STATUS_OFS: begin
          next_st.rdata[`CC_STAT_LOGIC_LSB +: 2] = st.con_logic;
          next_st.rdata[`CC_STAT_SCALE_LSB +: 2] = st.con_scale;
          next_st.rdata[`CC_STAT_ANALOG_LSB +: 2] = st.con_analog;
          next_st.rdata[`CC_STAT_SLAVE_BIT] = follower_en;
          next_st.rdata[`CC_STAT_EN_LSB +: 5] = {ovl_en, clock_en, analog_en, scale_en,
                                                 logic_en};
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // selections move only on the active logic clock so the program sees clean steps
    if (active_tick) begin
      next_st.con_logic = logic_en ? patched_logic : st.panel_logic;
      next_st.con_scale = scale_en ? patched_scale : st.panel_scale;
      next_st.con_analog = analog_en ? patched_analog : st.panel_analog;
    end
    // patchboard pins drive 0 V for logic one
    next_st.pins.system_halt_out = ~st.panel_logic[1];
    next_st.pins.system_run_out = ~st.panel_logic[0];
    next_st.pins.system_scale_tens_out = ~st.panel_scale[0];
    next_st.pins.system_scale_hundreds_out = ~st.panel_scale[1];
    next_st.pins.logic_timebase_out = ~tb_level;
    next_st.pins.follower_button_out = ~st.slave_button;
    next_st.pins.overload_report_out = ~(ovl_en & overload_detect);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.panel_logic <= logic_mode_t'(`CC_PANEL_LOGIC_RST);
      st.panel_scale <= time_scale_t'(`CC_PANEL_SCALE_RST);
      st.panel_analog <= analog_mode_t'(`CC_PANEL_ANALOG_RST);
      st.slave_button <= `CC_PANEL_SLAVE_RST;
      st.con_logic <= LM_LOAD;
      st.con_scale <= TS_X1;
      st.con_analog <= AM_IC;
      st.ext_prev <= 1'b0;
      st.tick <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.pins <= 7'h7F;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign board_n = st.pins;
  assign console_logic_mode = st.con_logic;
  assign console_scale = st.con_scale;
  assign console_analog_mode = st.con_analog;
  assign logic_tick = st.tick;

  property p_sys_logic_out;
    @(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == `CC_PANEL_OFS && !reg_wdata[1]) |-> ##2
      (board_n.system_halt_out == 1'b1 && board_n.system_run_out == ~$past(reg_wdata[0], 2));
  endproperty
  a_sys_logic_out: assert property (p_sys_logic_out)
    else $error("system logic mode pins do not match panel write");

  property p_sys_stop_out;
    @(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == `CC_PANEL_OFS && reg_wdata[1]) |-> ##2
      (board_n.system_halt_out == 1'b0 && board_n.system_run_out == 1'b1);
  endproperty
  a_sys_stop_out: assert property (p_sys_stop_out)
    else $error("stop is not shown as halt 1 run 0");

  property p_patched_stop;
    @(posedge mclk) disable iff (rst)
    (active_tick && logic_en && !patch_n.console_halt_in) |=> (console_logic_mode == LM_STOP);
  endproperty
  a_patched_stop: assert property (p_patched_stop)
    else $error("patched halt did not select stop");

  property p_panel_logic_kept;
    @(posedge mclk) disable iff (rst)
    (active_tick && !logic_en) |=> (console_logic_mode == $past(st.panel_logic));
  endproperty
  a_panel_logic_kept: assert property (p_panel_logic_kept)
    else $error("console logic mode left panel selection without override");

  property p_patched_run;
    @(posedge mclk) disable iff (rst)
    (active_tick && follower_en && patch_n.console_halt_in && !patch_n.console_run_in)
      |=> (console_logic_mode == LM_RUN);
  endproperty
  a_patched_run: assert property (p_patched_run)
    else $error("follower enable did not hand logic mode to patched inputs");

  property p_sys_scale_out;
    @(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == `CC_PANEL_OFS) |-> ##2
      ({board_n.system_scale_hundreds_out, board_n.system_scale_tens_out}
        == ~$past(reg_wdata[3:2], 2));
  endproperty
  a_sys_scale_out: assert property (p_sys_scale_out)
    else $error("system time scale pins do not match panel write");

  property p_patched_scale;
    @(posedge mclk) disable iff (rst)
    (active_tick && scale_en) |=>
      (console_scale == {~$past(patch_n.console_scale_hundreds_in),
                         ~$past(patch_n.console_scale_tens_in)});
  endproperty
  a_patched_scale: assert property (p_patched_scale)
    else $error("console scale did not follow patched scale inputs");

  property p_ext_tick;
    @(posedge mclk) disable iff (rst)
    (ext_sel && ext_rise) |=> logic_tick;
  endproperty
  a_ext_tick: assert property (p_ext_tick)
    else $error("outside time base edge gave no logic tick");

  property p_int_tick;
    @(posedge mclk) disable iff (rst)
    (!ext_sel && !tb_rise) |=> !logic_tick;
  endproperty
  a_int_tick: assert property (p_int_tick)
    else $error("logic tick without internal time base edge");

  property p_follower_out;
    @(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == `CC_PANEL_OFS) |-> ##2
      (board_n.follower_button_out == ~$past(reg_wdata[6], 2));
  endproperty
  a_follower_out: assert property (p_follower_out)
    else $error("follower output does not show slave button");

  property p_overload_gate;
    @(posedge mclk) disable iff (rst)
    (!ovl_en) |=> board_n.overload_report_out;
  endproperty
  a_overload_gate: assert property (p_overload_gate)
    else $error("overload reported while gate is off");

  property p_master_hold;
    @(posedge mclk) disable iff (rst)
    (active_tick && analog_en && !patch_n.console_master_hold_in)
      |=> (console_analog_mode == AM_MHOLD);
  endproperty
  a_master_hold: assert property (p_master_hold)
    else $error("patched master hold not taken");

  property p_patched_load;
    @(posedge mclk) disable iff (rst)
    (active_tick && logic_en && patch_n.console_halt_in && patch_n.console_run_in)
      |=> (console_logic_mode == LM_LOAD);
  endproperty
  a_patched_load: assert property (p_patched_load)
    else $error("patched inputs both zero did not select load");

  property p_panel_scale_kept;
    @(posedge mclk) disable iff (rst)
    (active_tick && !scale_en) |=> (console_scale == $past(st.panel_scale));
  endproperty
  a_panel_scale_kept: assert property (p_panel_scale_kept)
    else $error("console scale left panel selection without override");

  property p_panel_analog_kept;
    @(posedge mclk) disable iff (rst)
    (active_tick && !analog_en) |=> (console_analog_mode == $past(st.panel_analog));
  endproperty
  a_panel_analog_kept: assert property (p_panel_analog_kept)
    else $error("console analog mode left panel selection without override");

  property p_hold_over_operate;
    @(posedge mclk) disable iff (rst)
    (active_tick && analog_en && patch_n.console_master_hold_in && !patch_n.console_hold_in)
      |=> (console_analog_mode == AM_HOLD);
  endproperty
  a_hold_over_operate: assert property (p_hold_over_operate)
    else $error("patched hold not taken");

  property p_overload_pass;
    @(posedge mclk) disable iff (rst)
    (ovl_en && overload_detect) |=> !board_n.overload_report_out;
  endproperty
  a_overload_pass: assert property (p_overload_pass)
    else $error("gated overload not reported");

  property p_follower_overload;
    @(posedge mclk) disable iff (rst)
    (follower_en && overload_detect) |=> !board_n.overload_report_out;
  endproperty
  a_follower_overload: assert property (p_follower_overload)
    else $error("follower enable did not gate overload out");

  // internal base: one rise every 200 mclk cycles, high for half of them
  property p_tb_period;
    @(posedge mclk) disable iff (rst)
    tb_rise |-> ##200 tb_rise;
  endproperty
  a_tb_period: assert property (p_tb_period)
    else $error("internal time base period is not 1 us");

  property p_tb_high_time;
    @(posedge mclk) disable iff (rst)
    $rose(tb_level) |-> ##100 $fell(tb_level);
  endproperty
  a_tb_high_time: assert property (p_tb_high_time)
    else $error("internal time base is not half high");

  property p_timebase_pin;
    @(posedge mclk) disable iff (rst)
    $rose(tb_level) |=> !board_n.logic_timebase_out;
  endproperty
  a_timebase_pin: assert property (p_timebase_pin)
    else $error("time base pin did not follow internal time base");

  property p_selections_held;
    @(posedge mclk) disable iff (rst)
    !active_tick |=> ($stable(console_logic_mode) && $stable(console_scale)
      && $stable(console_analog_mode));
  endproperty
  a_selections_held: assert property (p_selections_held)
    else $error("console selection moved without a logic tick");

endmodule
`default_nettype wire

// >>> master_console_model.sv
// far-side model: patched logic program and master console over trunks
`timescale 1ns/100ps
`default_nettype none

module master_console_model
  import console_ctl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // selections of the far side, logic level
  input wire patch_pins_n_t want,
  input wire logic step,
  input wire logic trunk,
  input wire time_scale_t master_scale,
  // pins towards the console
  output patch_pins_n_t patch_n
);
  logic [1:0] low_cnt;

  // clock pin low two cycles, then high at least one before the next step
  // steps come far slower than mclk, so the follower is the faster console
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt <= 2'h0;
    end else if (step && low_cnt == 2'h0) begin
      low_cnt <= 2'h2;
    end else if (low_cnt != 2'h0) begin
      low_cnt <= low_cnt - 2'h1;
    end
  end

  always_comb begin
    patch_n = ~want;
    if (trunk) begin
      patch_n.console_scale_tens_in = ~master_scale[0];
      patch_n.console_scale_hundreds_in = ~master_scale[1];
    end
    patch_n.outside_timebase_in = (low_cnt == 2'h0);
  end
endmodule

`default_nettype wire

// >>> test_console_mode_override.sv
// self-checking bench of the console control block
`timescale 1ns/100ps
`default_nettype none

module test_console_mode_override;
  import console_ctl_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  patch_pins_n_t want = '0;
  patch_pins_n_t patch_n;
  board_pins_n_t board_n;
  logic overload_detect = 1'b0;
  logic step = 1'b0;
  logic trunk = 1'b0;
  time_scale_t master_scale = TS_X1;
  logic_mode_t console_logic_mode;
  time_scale_t console_scale;
  analog_mode_t console_analog_mode;
  logic logic_tick;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00011968;

  always #2.5 mclk = ~mclk;

  console_mode_override dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .patch_n(patch_n), .board_n(board_n),
    .overload_detect(overload_detect), .console_logic_mode(console_logic_mode),
    .console_scale(console_scale), .console_analog_mode(console_analog_mode),
    .logic_tick(logic_tick));

  master_console_model far_end (
    .mclk(mclk), .rst(rst), .want(want), .step(step), .trunk(trunk),
    .master_scale(master_scale), .patch_n(patch_n));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [1:0] exp_logic(logic en, logic h, logic r, logic [1:0] p);
    if (!en) return (p == 2'h3) ? 2'h2 : p;
    return h ? 2'h2 : {1'b0, r};
  endfunction

  function automatic logic [1:0] exp_analog(logic en, logic mh, logic h, logic op,
                                            logic [1:0] p);
    if (!en) return p;
    return mh ? 2'h3 : (h ? 2'h2 : {1'b0, op});
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // an idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic tick_wait();
    @(posedge mclk);
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    for (int k = 0; k < 10 && logic_tick !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    check("logic tick", 32'(logic_tick), 32'h00000001);
    if (logic_tick !== 1'b1) print_verdict();
  endtask

  task automatic count400(output int ticks, output int lows);
    ticks = 0;
    lows = 0;
    repeat (400) begin
      @(posedge mclk);
      #1;
      ticks += (logic_tick === 1'b1);
      lows += (board_n.logic_timebase_out === 1'b0);
    end
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [6:0] panel;
    patch_pins_n_t w;
    logic [4:0] en;
    logic [1:0] lm_exp;
    logic [1:0] ts;
    logic [1:0] am_exp;
    int ticks;
    int lows;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("board pins", 32'(board_n), 32'h0000007F);
    check("logic mode", 32'(console_logic_mode), 32'h00000000);
    rd(8'h00, d);
    check("panel reset", d, 32'h00000000);
    w = '0;
    w.outside_timebase_en = 1'b1;
    want <= w;
    // every logic mode and time scale from the panel
    for (int i = 0; i < 16; i++) begin
      r = xorshift();
      panel = {r[6:4], i[3:2], i[1:0]};
      wr(8'h00, 32'(panel));
      #1;
      check("halt pin", 32'(board_n.system_halt_out), 32'(!i[1]));
      check("run pin", 32'(board_n.system_run_out), 32'(i[1:0] != 2'h1));
      check("tens pin", 32'(board_n.system_scale_tens_out), 32'(!i[2]));
      check("hundreds pin", 32'(board_n.system_scale_hundreds_out), 32'(!i[3]));
      check("follower pin", 32'(board_n.follower_button_out), 32'(!r[6]));
      lm_exp = exp_logic(1'b0, 1'b0, 1'b0, panel[1:0]);
      rd(8'h00, d);
      check("panel", d, 32'({panel[6:2], lm_exp}));
      tick_wait();
      check("panel logic", 32'(console_logic_mode), 32'(lm_exp));
      check("panel scale", 32'(console_scale), 32'(panel[3:2]));
      check("panel analog", 32'(console_analog_mode), 32'(panel[5:4]));
    end
    wr(8'h04, 32'h0000007F);
    rd(8'h00, d);
    check("panel after status write", d, 32'({panel[6:2], lm_exp}));
    rd(8'h3C, d);
    check("unmapped read", d, 32'h00000000);
    // random patched overrides, unset inputs read as logic zero
    for (int i = 0; i < 40; i++) begin
      r = xorshift();
      w = patch_pins_n_t'(r[14:0]);
      w.follower_enable_in = r[15] & r[16];
      w.outside_timebase_en = 1'b1;
      trunk <= r[17];
      master_scale <= time_scale_t'(r[19:18]);
      overload_detect <= r[20];
      want <= w;
      repeat (3) @(posedge mclk);
      #1;
      check("held logic", 32'(console_logic_mode), 32'(lm_exp));
      tick_wait();
      en = {w.overload_gate_en, w.console_clock_override_en, w.console_analog_override_en,
            w.console_scale_override_en, w.console_logic_override_en};
      en = en | {5{w.follower_enable_in}};
      lm_exp = exp_logic(en[0], w.console_halt_in, w.console_run_in, panel[1:0]);
      check("logic", 32'(console_logic_mode), 32'(lm_exp));
      ts = r[17] ? r[19:18] : {w.console_scale_hundreds_in, w.console_scale_tens_in};
      ts = en[1] ? ts : panel[3:2];
      check("scale", 32'(console_scale), 32'(ts));
      am_exp = exp_analog(en[2], w.console_master_hold_in, w.console_hold_in,
                          w.console_operate_in, panel[5:4]);
      check("analog", 32'(console_analog_mode), 32'(am_exp));
      check("overload pin", 32'(board_n.overload_report_out), 32'(!(en[4] & r[20])));
      rd(8'h04, d);
      check("status", d, 32'({en, w.follower_enable_in, am_exp, ts, lm_exp}));
    end
    // internal time base, then the outside one with no steps
    want <= '0;
    trunk <= 1'b0;
    repeat (10) @(posedge mclk);
    // an outside edge while the outside time base is off must add no tick
    step <= 1'b1;
    @(posedge mclk);
    step <= 1'b0;
    count400(ticks, lows);
    check("internal ticks", 32'(ticks), 32'h00000002);
    check("time base low", 32'(lows), 32'h000000C8);
    @(posedge mclk);
    want <= w;
    repeat (10) @(posedge mclk);
    count400(ticks, lows);
    check("outside ticks", 32'(ticks), 32'h00000000);
    check("time base kept", 32'(lows), 32'h000000C8);
    print_verdict();
  end
endmodule

`default_nettype wire
